/* verilog/irq_tail_pkg.sv */
package irq_tail_pkg;
	// Register byte offsets (word aligned)
	localparam logic [7:0] OFF_NORMAL_VECTOR  = 8'h00;
	localparam logic [7:0] OFF_FAST_VECTOR    = 8'h04;
	localparam logic [7:0] OFF_EOI_CMD        = 8'h08;
	localparam logic [7:0] OFF_SPURIOUS       = 8'h0c;
	localparam logic [7:0] OFF_DEBUG          = 8'h10;
	localparam logic [7:0] OFF_FF_ENABLE      = 8'h14;
	localparam logic [7:0] OFF_FF_DISABLE     = 8'h18;
	localparam logic [7:0] OFF_FF_STATE       = 8'h1c;
	localparam logic [7:0] OFF_CORE_STATUS    = 8'h20;
	// Field positions
	localparam int         BIT_PROTECT        = 0;
	localparam int         BIT_GLOBAL_MASK    = 1;
	// Reset values
	localparam logic [31:0] RST_SPURIOUS      = 32'h00000000;
	localparam logic [1:0]  RST_DEBUG         = 2'h0;
	localparam logic [31:0] RST_FF_STATE      = 32'h00000000;
	localparam logic [31:0] FF_IMPL_MASK      = 32'hfffffffe;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage : irq_tail_pkg

/* verilog/fast_force_bits.sv */
`timescale 1ns/1ns
// Per-source fast forcing state with set and clear command words
module fast_force_bits #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic             enable,
	// Command words
	input  wire logic             setStrobe,
	input  wire logic             clearStrobe,
	input  wire logic [WIDTH-1:0] commandData,
	input  wire logic [WIDTH-1:0] implMask,
	// State
	output logic      [WIDTH-1:0] forceState
);
	// Ones set or clear, zeros leave bits alone; unimplemented bits stay zero
	always_ff @(posedge clock) begin
		if (reset) begin
			forceState <= '0;
		end else if (enable) begin
			if (setStrobe) begin
				forceState <= (forceState | commandData) & implMask; // see [R5] see [R8]
			end else if (clearStrobe) begin
				forceState <= forceState & ~commandData & implMask; // see [R6] see [R8]
			end
		end
	end
endmodule : fast_force_bits

/* verilog/irq_ctrl_eoi_spurious_fastforce.sv */
// Notes on behaviour
// [R1] Any write to the end-of-interrupt location ends the current interrupt.
// [R2] Spurious handler address is stored and returned on spurious vector reads.
// [R3] Debug bit 0 turns protection mode on or off; register resets to zero.
// [R4] Global mask set holds both processor interrupt lines inactive.
// [R5] Writing one to a fast-force enable bit turns forcing on; zero ignored. Here only full-word writes (all four strobes) act.
// [R6] Writing one to a fast-force disable bit turns forcing off; zero ignored. Here only full-word writes (all four strobes) act.
// [R7] Fast-force status reads one where forcing is on, zero where off.
// [R8] Only sources 1 to 31 have fast forcing; bit 0 is unimplemented.
// [R9] In protection mode a vector read changes nothing; a later write advances.
// [R10] Handler writes end-of-interrupt once per serviced interrupt before returning.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module irq_ctrl_eoi_spurious_fastforce
	import irq_tail_pkg::*;
#(
	parameter int SOURCES = 32
) (
	// Clock, reset, enable
	input  wire logic               clock,
	input  wire logic               reset,
	input  wire logic               clockEnable,
	// AXI4-Lite write address
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// From the priority logic (same clock)
	input  wire logic               normalRequest,
	input  wire logic               fastRequest,
	input  wire logic               normalSpurious,
	input  wire logic               fastSpurious,
	input  wire logic [31:0]        normalVectorIn,
	input  wire logic [31:0]        fastVectorIn,
	// To the priority logic
	output logic                    vectorAdvance,
	output logic                    endOfInterrupt,
	output logic [SOURCES-1:0]      fastForceState,
	// Processor interrupt lines, active low
	output logic                    normal_int_line_n,
	output logic                    fast_int_line_n
);
	import irq_tail_pkg::*;

	// Write channel capture; address and data may arrive in either order
	logic [7:0]         writeAddr;
	logic [31:0]        writeData;
	logic [3:0]         writeStrb;
	logic               haveAddr;
	logic               haveData;
	logic               writeFire;
	logic [31:0]        spurious_handler_address;
	logic               protect_mode_bit;
	logic               global_line_mask;
	logic [SOURCES-1:0] ffState;
	logic               writeKnown;
	logic               writeFull;

	assign writeFire  = haveAddr && haveData && !s_axi_bvalid;
	assign writeFull  = (writeStrb == 4'hf);
	assign writeKnown = (writeAddr == OFF_EOI_CMD) || (writeAddr == OFF_SPURIOUS) ||
	                    (writeAddr == OFF_DEBUG) || (writeAddr == OFF_FF_ENABLE) ||
	                    (writeAddr == OFF_FF_DISABLE) || (writeAddr == OFF_NORMAL_VECTOR);

	// Address channel: ready while no address is held and no write response is pending
	always_ff @(posedge clock) begin
		if (reset) begin
			haveAddr      <= 1'b0;
			writeAddr     <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (clockEnable) begin
			if (s_axi_awvalid && s_axi_awready) begin
				haveAddr      <= 1'b1;
				writeAddr     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (writeFire) begin
				haveAddr      <= 1'b0;
			end else begin
				s_axi_awready <= !haveAddr && !s_axi_bvalid;
			end
		end
	end

	// Data channel: mirrors the address channel
	always_ff @(posedge clock) begin
		if (reset) begin
			haveData     <= 1'b0;
			writeData    <= 32'h00000000;
			writeStrb    <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (clockEnable) begin
			if (s_axi_wvalid && s_axi_wready) begin
				haveData     <= 1'b1;
				writeData    <= s_axi_wdata;
				writeStrb    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (writeFire) begin
				haveData     <= 1'b0;
			end else begin
				s_axi_wready <= !haveData && !s_axi_bvalid;
			end
		end
	end

	// Response after both halves; unmapped or read-only targets get SLVERR
	always_ff @(posedge clock) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (clockEnable) begin
			if (writeFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= writeKnown ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// End of interrupt: data value and strobes do not matter
	always_ff @(posedge clock) begin
		if (reset) begin
			endOfInterrupt <= 1'b0;
		end else if (clockEnable) begin
			endOfInterrupt <= writeFire && (writeAddr == OFF_EOI_CMD); // see [R1] see [R10]
		end
	end

	// Spurious handler address, byte lanes honoured
	always_ff @(posedge clock) begin
		if (reset) begin
			spurious_handler_address <= RST_SPURIOUS;
		end else if (clockEnable && writeFire && writeAddr == OFF_SPURIOUS) begin
			for (int i = 0; i < 4; i++) begin
				if (writeStrb[i]) begin
					spurious_handler_address[8*i +: 8] <= writeData[8*i +: 8]; // see [R2]
				end
			end
		end
	end

	// Debug control; only the low byte holds live bits
	always_ff @(posedge clock) begin
		if (reset) begin
			protect_mode_bit <= RST_DEBUG[BIT_PROTECT];
			global_line_mask <= RST_DEBUG[BIT_GLOBAL_MASK];
		end else if (clockEnable && writeFire && writeAddr == OFF_DEBUG && writeStrb[0]) begin
			protect_mode_bit <= writeData[BIT_PROTECT]; // see [R3]
			global_line_mask <= writeData[BIT_GLOBAL_MASK];
		end
	end

	// Fast forcing needs the full word so that no source is half-written
	fast_force_bits #(
		.WIDTH(SOURCES)
	) u_fast_force (
		.clock      (clock),
		.reset      (reset),
		.enable     (clockEnable),
		.setStrobe  (writeFire && writeAddr == OFF_FF_ENABLE && writeFull),
		.clearStrobe(writeFire && writeAddr == OFF_FF_DISABLE && writeFull),
		.commandData(writeData[SOURCES-1:0]),
		.implMask   (FF_IMPL_MASK[SOURCES-1:0]),
		.forceState (ffState)
	);

	always_ff @(posedge clock) begin
		if (reset) begin
			fastForceState <= '0;
		end else if (clockEnable) begin
			fastForceState <= ffState;
		end
	end

	// Read channel
	logic [31:0] readValue;
	logic        readKnown;
	logic        readAdvance;

	// Read decode
	always_comb begin
		readValue = 32'h00000000;
		readKnown = 1'b1;
		unique case (s_axi_araddr)
			OFF_NORMAL_VECTOR: readValue = normalSpurious ? spurious_handler_address : normalVectorIn; // see [R2]
			OFF_FAST_VECTOR:   readValue = fastSpurious ? spurious_handler_address : fastVectorIn; // see [R2]
			OFF_SPURIOUS:      readValue = spurious_handler_address;
			OFF_DEBUG:         readValue = {30'h00000000, global_line_mask, protect_mode_bit};
			OFF_FF_STATE:      readValue = 32'(ffState) & FF_IMPL_MASK; // see [R7] see [R8]
			OFF_CORE_STATUS:   readValue = {30'h00000000, !normal_int_line_n, !fast_int_line_n};
			default: begin
				readKnown = 1'b0;
			end
		endcase
	end

	// Reading the normal vector advances state unless protection is on
	assign readAdvance = s_axi_arvalid && s_axi_arready &&
	                     (s_axi_araddr == OFF_NORMAL_VECTOR) && !protect_mode_bit; // see [R9]

	always_ff @(posedge clock) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (clockEnable) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= readValue;
				s_axi_rresp   <= readKnown ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Advance pulse: from a read normally, from a write in protection mode
	always_ff @(posedge clock) begin
		if (reset) begin
			vectorAdvance <= 1'b0;
		end else if (clockEnable) begin
			vectorAdvance <= readAdvance ||
			                 (writeFire && writeAddr == OFF_NORMAL_VECTOR && protect_mode_bit); // see [R9]
		end
	end

	// Lines are registered so the core never sees a glitch from the mask
	always_ff @(posedge clock) begin
		if (reset) begin
			normal_int_line_n <= 1'b1;
			fast_int_line_n   <= 1'b1;
		end else if (clockEnable) begin
			normal_int_line_n <= !(normalRequest && !global_line_mask); // see [R4]
			fast_int_line_n   <= !(fastRequest && !global_line_mask); // see [R4]
		end
	end
endmodule : irq_ctrl_eoi_spurious_fastforce

/* test/irq_tail_properties.sv */
`timescale 1ns/1ns
module irq_tail_properties
	import irq_tail_pkg::*;
#(
	parameter int SOURCES = 32
) (
	// Clock and reset
	input wire logic	clock,
	input wire logic	reset,
	input wire logic	clockEnable,
	// Bus handshakes
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic	s_axi_bvalid,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic	s_axi_rvalid,
	// Controller side
	input wire logic	normalRequest,
	input wire logic	fastRequest,
	input wire logic	vectorAdvance,
	input wire logic	endOfInterrupt,
	input wire logic [SOURCES-1:0]	fastForceState,
	input wire logic	normal_int_line_n,
	input wire logic	fast_int_line_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// Both write halves taken on one edge
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clockEnable;
	endsequence
	AST_EOI_PULSE: assert property (endOfInterrupt |=> !endOfInterrupt)
		else $error("end of interrupt pulse too long");
	AST_EOI_ACK: assert property (endOfInterrupt |-> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
		else $error("end of interrupt without okay response");
	AST_FF_BIT0: assert property (fastForceState[0] == 1'b0)
		else $error("fast force bit 0 set");
	AST_NORMAL_IDLE: assert property (clockEnable && !normalRequest |=> normal_int_line_n)
		else $error("normal line active without request");
	AST_FAST_IDLE: assert property (clockEnable && !fastRequest |=> fast_int_line_n)
		else $error("fast line active without request");
	AST_WRITE_ANSWER: assert property (wrTaken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready && clockEnable |=> s_axi_rvalid)
		else $error("read data late");
	AST_ADV_PULSE: assert property (vectorAdvance |=> !vectorAdvance)
		else $error("advance pulse too long");
	AST_ADV_CAUSE: assert property (vectorAdvance |-> s_axi_rvalid || s_axi_bvalid)
		else $error("advance without access");
endmodule : irq_tail_properties
bind irq_ctrl_eoi_spurious_fastforce irq_tail_properties #(.SOURCES(SOURCES)) irq_tail_properties_i (
	.clock, .reset, .clockEnable, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .normalRequest,
	.fastRequest, .vectorAdvance, .endOfInterrupt, .fastForceState, .normal_int_line_n, .fast_int_line_n);

/* test/core_model.sv */
`timescale 1ns/1ns
module core_model (
	// Clock and reset
	input wire logic	clock,
	input wire logic	reset,
	// Lines from the controller
	input wire logic	normal_int_line_n,
	input wire logic	fast_int_line_n,
	// Cycles each line was seen active
	output logic [15:0]	normalCount,
	output logic [15:0]	fastCount
);
	// Level sensitive lines, so the core samples them every cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			normalCount <= 16'h0000;
			fastCount <= 16'h0000;
		end else begin
			normalCount <= normalCount + {15'h0000, !normal_int_line_n};
			fastCount <= fastCount + {15'h0000, !fast_int_line_n};
		end
	end
endmodule : core_model

/* test/tb_irq_ctrl_eoi_spurious_fastforce.sv */
`timescale 1ns/1ns
module tb_irq_ctrl_eoi_spurious_fastforce;
	import irq_tail_pkg::*;
	logic	clock, reset, clockEnable, normalRequest, fastRequest, normalSpurious, fastSpurious;
	logic	s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic	s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, vectorAdvance, endOfInterrupt;
	logic	normal_int_line_n, fast_int_line_n;
	logic [7:0]	s_axi_awaddr, s_axi_araddr;
	logic [3:0]	s_axi_wstrb;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic [31:0]	s_axi_wdata, s_axi_rdata, normalVectorIn, fastVectorIn, fastForceState;
	logic [15:0]	normalCount, fastCount, n0, f0;
	int	num_errors, n_tests, eoiCount, advCount;
	irq_ctrl_eoi_spurious_fastforce #(.SOURCES(32)) irq_ctrl_eoi_spurious_fastforce_i (.clock, .reset,
		.clockEnable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.normalRequest, .fastRequest, .normalSpurious, .fastSpurious, .normalVectorIn, .fastVectorIn,
		.vectorAdvance, .endOfInterrupt, .fastForceState, .normal_int_line_n, .fast_int_line_n);
	core_model core_model_i (.clock, .reset, .normal_int_line_n, .fast_int_line_n, .normalCount, .fastCount);
	// Free running clock
	always #5 clock = !clock;
	// Count one-cycle pulses mid-cycle so the count never races the checks at the edge
	always @(negedge clock) begin
		if (endOfInterrupt === 1'b1) eoiCount++;
		if (vectorAdvance === 1'b1) advCount++;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic test_done();
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	// A hung handshake ends the run rather than the simulator
	task automatic tick(inout int n);
		n++;
		if (n > 40) begin
			num_errors++;
			test_done();
		end
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			tick(n);
		end while (s_axi_bvalid !== 1'b1);
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			tick(n);
		end while (s_axi_rvalid !== 1'b1);
		check("rdata", s_axi_rdata, exp);
		check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask : rd
	initial begin
		{clock, clockEnable, reset, s_axi_wstrb} = 7'h3f;
		{normalRequest, fastRequest, normalSpurious, fastSpurious} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{normalVectorIn, fastVectorIn, num_errors, n_tests, eoiCount, advCount} = 192'h0;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rd(OFF_DEBUG, 32'h00000000, RESP_OKAY);
		rd(OFF_SPURIOUS, 32'h00000000, RESP_OKAY);
		rd(OFF_FF_STATE, 32'h00000000, RESP_OKAY);
		wr(OFF_SPURIOUS, 32'h5a5ac3c3, RESP_OKAY);
		normalVectorIn <= 32'h00001234;
		fastVectorIn <= 32'h00005678;
		rd(OFF_NORMAL_VECTOR, 32'h00001234, RESP_OKAY);
		normalSpurious <= 1'b1;
		fastSpurious <= 1'b1;
		rd(OFF_NORMAL_VECTOR, 32'h5a5ac3c3, RESP_OKAY);
		rd(OFF_FAST_VECTOR, 32'h5a5ac3c3, RESP_OKAY);
		check("advance", advCount, 2);
		// Protection mode: reads leave the priority logic alone
		wr(OFF_DEBUG, 32'h00000001, RESP_OKAY);
		rd(OFF_DEBUG, 32'h00000001, RESP_OKAY);
		rd(OFF_NORMAL_VECTOR, 32'h5a5ac3c3, RESP_OKAY);
		check("advance", advCount, 2);
		wr(OFF_NORMAL_VECTOR, 32'h00000000, RESP_OKAY);
		check("advance", advCount, 3);
		wr(OFF_DEBUG, 32'h00000000, RESP_OKAY);
		// Handler closes two interrupts with arbitrary data
		wr(OFF_EOI_CMD, 32'h00000000, RESP_OKAY);
		wr(OFF_EOI_CMD, 32'hffffffff, RESP_OKAY);
		check("eoi", eoiCount, 2);
		wr(OFF_FF_ENABLE, 32'hffffffff, RESP_OKAY);
		rd(OFF_FF_STATE, 32'hfffffffe, RESP_OKAY);
		check("ffport", fastForceState, 32'hfffffffe);
		wr(OFF_FF_DISABLE, 32'h0000000f, RESP_OKAY);
		wr(OFF_FF_ENABLE, 32'h00000001, RESP_OKAY);
		wr(OFF_FF_DISABLE, 32'h00000000, RESP_OKAY);
		rd(OFF_FF_STATE, 32'hfffffff0, RESP_OKAY);
		wr(OFF_FF_ENABLE, 32'h00000006, RESP_OKAY);
		wr(OFF_FF_STATE, 32'h00000000, RESP_SLVERR);
		rd(OFF_FF_STATE, 32'hfffffff6, RESP_OKAY);
		rd(8'h24, 32'h00000000, RESP_SLVERR);
		// Global mask holds both lines inactive despite requests
		wr(OFF_DEBUG, 32'h00000002, RESP_OKAY);
		normalRequest <= 1'b1;
		fastRequest <= 1'b1;
		n0 = normalCount;
		f0 = fastCount;
		repeat (8) @(posedge clock);
		check("normal", {16'h0, normalCount}, {16'h0, n0});
		check("fast", {16'h0, fastCount}, {16'h0, f0});
		wr(OFF_DEBUG, 32'h00000000, RESP_OKAY);
		// Lines follow one edge after the mask, and the core counts one edge later
		repeat (2) @(posedge clock);
		check("normalon", {31'h0, normalCount != n0}, 32'h1);
		check("faston", {31'h0, fastCount != f0}, 32'h1);
		rd(OFF_CORE_STATUS, 32'h00000003, RESP_OKAY);
		// Enable low freezes the lines although the requests drop
		clockEnable <= 1'b0;
		normalRequest <= 1'b0;
		fastRequest <= 1'b0;
		repeat (4) @(posedge clock);
		check("frozen", {31'h0, normal_int_line_n}, 32'h0);
		clockEnable <= 1'b1;
		repeat (2) @(posedge clock);
		check("released", {31'h0, normal_int_line_n}, 32'h1);
		// Reset in mid-run returns the registers to their defaults
		wr(OFF_DEBUG, 32'h00000001, RESP_OKAY);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rd(OFF_DEBUG, 32'h00000000, RESP_OKAY);
		rd(OFF_FF_STATE, 32'h00000000, RESP_OKAY);
		test_done();
	end
endmodule : tb_irq_ctrl_eoi_spurious_fastforce
